/* File: src/axis_drive_mode_config.sv */
// Operation
// - two-pulse splits by direction; else pulse plus dir
// - pulse polarity bit inverts drive pulses
// - direction polarity bit sets dir output level
// - encoder type selects quadrature or up/down
// - quadrature counts all edges, A leads up
// - up/down counts rising edges of A, B
// - quadrature division 1, 1/2, 1/4; 11 invalid
// - alarm level selectable; enable gates checking
// - active alarm sets error bit, stops drive
// - in-position holds busy until input active
// - both mode registers clear on reset
// - manual or automatic deceleration select
// - separate deceleration rate select
// - trapezoid or S-curve profile select
// - external drive field selects four modes
// - continuous while low, fixed on falling
// - pulsar edges start plus/minus, minus input low
// - triangle prevention enable bit
// - position counter ring enable bit
// - output select routes register or status
// - status outputs carry profile and compare state
// - filter enables per input group
// - filter code sets delay 2us or 256us doubling
// - pulse format bit selects output type
//
// Strobed register access and the placing of the registers are this design's own decisions.
module axis_drive_mode_config
    import axis_mode_pkg::*;
#(
    parameter int POS_W = 32
) (
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         sys_rst_i,
    // register port
    input  wire logic [2:0]   reg_addr_i,
    input  wire logic [15:0]  reg_wdata_i,
    input  wire logic         reg_wr_i,
    input  wire logic         reg_rd_i,
    output logic      [15:0]  reg_rdata_o,
    // drive core side
    input  wire logic         core_pulse_i,
    input  wire logic         core_dir_minus_i,
    input  drive_state_t      core_state_i,
    output profile_cfg_t      profile_cfg_o,
    output ext_req_t          ext_req_o,
    output logic              drive_stop_o,
    output logic              axis_drive_busy_o,
    output logic [15:0]       filtered_in_o,
    // pins
    input  wire logic [15:0]  raw_in_i,
    input  wire logic         encoder_a_up_in_i,
    input  wire logic         encoder_b_down_in_i,
    output logic              pulse_plus_out_o,
    output logic              minus_dir_out_o,
    output logic [7:0]        axis_outputs_o
);
    // raw_in_i bits: 0 emergency, 1 plus limit, 2 minus limit, 3 stop0,
    // 4 stop1, 5 stop2, 6 in-position, 7 alarm, 8 ext plus, 9 ext minus,
    // 10..15 general inputs 0..5

    logic [15:0]      io_mode_q;
    logic [15:0]      drv_filt_q;
    logic [7:0]       gen_out_q;
    logic             alarm_q;
    logic             busy_q;
    logic [POS_W-1:0] pos_q;
    logic [15:0]      rdata_q;

    // group enables spread over the sixteen filtered inputs
    function automatic logic [15:0] group_mask(input logic [4:0] fe);
        group_mask = {{6{fe[4]}}, {2{fe[3]}}, {2{fe[2]}}, fe[1], {5{fe[0]}}};
    endfunction

    // filter hold time in base ticks for a code
    function automatic logic [13:0] hold_ticks(input logic [2:0] code);
        if (code == 3'h0) begin
            hold_ticks = 14'h0001;
        end else begin
            hold_ticks = 14'(FILT_LONG_TICK) << (code - 3'h1);
        end
    endfunction

    // register writes
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            io_mode_q  <= IO_MODE_RST;
            drv_filt_q <= DRV_FILT_RST;
            gen_out_q  <= GEN_OUT_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == IO_MODE_ADDR) begin
                io_mode_q <= reg_wdata_i;
            end
            if (reg_addr_i == DRV_FILT_ADDR) begin
                drv_filt_q <= reg_wdata_i;
            end
            if (reg_addr_i == GEN_OUT_ADDR) begin
                gen_out_q <= reg_wdata_i[7:0];
            end
        end
    end

    // read data, valid only the cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                IO_MODE_ADDR:   rdata_q <= io_mode_q;
                DRV_FILT_ADDR:  rdata_q <= drv_filt_q;
                GEN_OUT_ADDR:   rdata_q <= {8'h00, gen_out_q};
                MAIN_STAT_ADDR: rdata_q <= 16'(busy_q) << BUSY_BIT;
                ERR_STAT_ADDR:  rdata_q <= 16'(alarm_q) << ALARM_BIT;
                POS_LO_ADDR:    rdata_q <= pos_q[15:0];
                POS_HI_ADDR:    rdata_q <= pos_q[31:16];
                default:        rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end
    assign reg_rdata_o = rdata_q;

    // profile settings steer the drive core
    assign profile_cfg_o.manual_decel_sel    = drv_filt_q[MAN_DECEL_BIT];
    assign profile_cfg_o.separate_decel_sel  = drv_filt_q[SEP_DECEL_BIT];
    assign profile_cfg_o.scurve_sel          = drv_filt_q[SCURVE_BIT];
    assign profile_cfg_o.triangle_prevent    = drv_filt_q[TRI_PREV_BIT];
    assign profile_cfg_o.counter_ring_enable = drv_filt_q[RING_EN_BIT];

    // input synchronisers and noise filters
    logic [15:0] sync1_q;
    logic [15:0] sync2_q;
    logic [15:0] filt_q;
    logic [13:0] hold_q [16];
    logic [5:0]  tick_cnt_q;
    logic        tick;
    logic [15:0] fen;
    logic [13:0] hold_lim;

    assign fen      = group_mask(drv_filt_q[FILT_EN_LSB +: 5]);
    assign hold_lim = hold_ticks(drv_filt_q[FILT_CODE_LSB +: 3]);
    assign tick     = (tick_cnt_q == 6'(FILT_BASE_CYC - 1));

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            sync1_q <= FILT_RST;
            sync2_q <= FILT_RST;
        end else begin
            sync1_q <= raw_in_i;
            sync2_q <= sync1_q;
        end
    end

    // base tick of the filter timers
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i || tick) begin
            tick_cnt_q <= 6'h00;
        end else begin
            tick_cnt_q <= tick_cnt_q + 6'h01;
        end
    end

    // each filter changes only after the new level held the delay
    for (genvar i = 0; i < 16; i++) begin : g_filt
        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
                filt_q[i] <= FILT_RST[i];
                hold_q[i] <= 14'h0000;
            end else if (!fen[i]) begin
                filt_q[i] <= sync2_q[i];
                hold_q[i] <= 14'h0000;
            end else if (sync2_q[i] == filt_q[i]) begin
                hold_q[i] <= 14'h0000;
            end else if (tick) begin
                if (hold_q[i] >= hold_lim) begin // first tick is partial, skip it
                    filt_q[i] <= sync2_q[i];
                    hold_q[i] <= 14'h0000;
                end else begin
                    hold_q[i] <= hold_q[i] + 14'h0001;
                end
            end
        end
    end
    assign filtered_in_o = filt_q;

    // servo alarm: sticky, write one to clear, set wins
    logic alarm_act;
    assign alarm_act = io_mode_q[ALM_EN_BIT]
                     & (filt_q[7] == io_mode_q[ALM_LEVEL_BIT]);
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            alarm_q <= 1'b0;
        end else if (alarm_act) begin
            alarm_q <= 1'b1;
        end else if (reg_wr_i && reg_addr_i == ERR_STAT_ADDR
                     && reg_wdata_i[ALARM_BIT]) begin
            alarm_q <= 1'b0;
        end
    end
    assign drive_stop_o = alarm_q;

    // busy stays up after pulses until in-position arrives
    logic inp_act;
    assign inp_act = (filt_q[6] == io_mode_q[INP_LEVEL_BIT]);
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= core_state_i.pulsing
                    | (busy_q & io_mode_q[INP_EN_BIT] & ~inp_act);
        end
    end
    assign axis_drive_busy_o = busy_q;

    // external drive inputs, active low
    ext_mode_t ext_mode;
    logic      expp_q;
    logic      expm_q;
    ext_req_t  ext_q;
    assign ext_mode = ext_mode_t'(drv_filt_q[EXT_MODE_LSB +: 2]);
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            expp_q <= 1'b1;
            expm_q <= 1'b1;
            ext_q  <= '0;
        end else begin
            expp_q <= filt_q[8];
            expm_q <= filt_q[9];
            ext_q  <= '0;
            unique case (ext_mode)
                EXT_OFF: begin
                end
                EXT_CONT: begin
                    ext_q.cont_plus  <= ~filt_q[8];
                    ext_q.cont_minus <= ~filt_q[9];
                end
                EXT_FIXED: begin
                    ext_q.fixed_plus  <= expp_q & ~filt_q[8];
                    ext_q.fixed_minus <= expm_q & ~filt_q[9];
                end
                EXT_PULSAR: begin
                    ext_q.fixed_plus  <= ~expp_q & filt_q[8] & ~filt_q[9];
                    ext_q.fixed_minus <= expp_q & ~filt_q[8] & ~filt_q[9];
                end
            endcase
        end
    end
    assign ext_req_o = ext_q;

    // pulse and direction formatting
    logic pp_q;
    logic pm_q;
    logic pls_act;
    logic mdir_act;
    always_comb begin
        if (io_mode_q[PULSE_FMT_BIT]) begin
            pls_act  = core_pulse_i;
            mdir_act = core_dir_minus_i ^ io_mode_q[DIR_POL_BIT];
        end else begin
            pls_act  = core_pulse_i & ~core_dir_minus_i;
            mdir_act = core_pulse_i & core_dir_minus_i;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pp_q <= 1'b0;
            pm_q <= 1'b0;
        end else begin
            pp_q <= pls_act ^ io_mode_q[PULSE_POL_BIT];
            pm_q <= io_mode_q[PULSE_FMT_BIT] ? mdir_act
                  : mdir_act ^ io_mode_q[PULSE_POL_BIT];
        end
    end
    assign pulse_plus_out_o = pp_q;
    assign minus_dir_out_o  = pm_q;

    // general outputs or live status
    logic [7:0] out_q;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            out_q <= 8'h00;
        end else if (drv_filt_q[OUT_SRC_BIT]) begin
            out_q <= core_state_i;
        end else begin
            out_q <= gen_out_q;
        end
    end
    assign axis_outputs_o = out_q;

    // encoder decode into the real position counter
    logic [1:0] enc1_q;
    logic [1:0] enc2_q;
    logic [1:0] enc3_q;
    logic       up;
    logic       dn;
    logic [2:0] steps;
    logic signed [3:0] frac_q;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            enc1_q <= 2'b00;
            enc2_q <= 2'b00;
            enc3_q <= 2'b00;
        end else begin
            enc1_q <= {encoder_b_down_in_i, encoder_a_up_in_i};
            enc2_q <= enc1_q;
            enc3_q <= enc2_q;
        end
    end

    always_comb begin
        up = 1'b0;
        dn = 1'b0;
        if (io_mode_q[ENC_TYPE_BIT]) begin
            up = enc2_q[0] & ~enc3_q[0];
            dn = enc2_q[1] & ~enc3_q[1];
        end else if (enc2_q != enc3_q) begin
            // a leads: b takes old a, a takes inverted old b
            up = (enc2_q[1] == enc3_q[0]) && (enc2_q[0] != enc3_q[1]);
            dn = (enc2_q[0] == enc3_q[1]) && (enc2_q[1] != enc3_q[0]);
        end
        unique case (io_mode_q[ENC_DIV_LSB +: 2])
            2'b00:   steps = 3'h1;
            2'b01:   steps = 3'h2;
            2'b10:   steps = 3'h4;
            default: steps = 3'h0;
        endcase
        if (io_mode_q[ENC_TYPE_BIT]) begin
            steps = 3'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pos_q  <= '0;
            frac_q <= 4'sh0;
        end else if (steps != 3'h0 && (up ^ dn)) begin
            if (up && frac_q + 4'sh1 >= $signed({1'b0, steps})) begin
                pos_q  <= pos_q + POS_W'(1);
                frac_q <= 4'sh0;
            end else if (dn && frac_q - 4'sh1 <= -$signed({1'b0, steps})) begin
                pos_q  <= pos_q - POS_W'(1);
                frac_q <= 4'sh0;
            end else begin
                frac_q <= up ? frac_q + 4'sh1 : frac_q - 4'sh1;
            end
        end
    end

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_two_pulse;
        !io_mode_q[PULSE_FMT_BIT] && !io_mode_q[PULSE_POL_BIT] && core_pulse_i
            && !core_dir_minus_i |=> pulse_plus_out_o && !minus_dir_out_o;
    endproperty
    a_two_pulse: assert property (p_two_pulse) else $error("plus pulse misrouted");

    property p_neg_pol;
        $stable(io_mode_q) && io_mode_q[PULSE_POL_BIT] && !core_pulse_i
            |=> pulse_plus_out_o;
    endproperty
    a_neg_pol: assert property (p_neg_pol) else $error("idle level wrong");

    property p_dir_pol;
        io_mode_q[PULSE_FMT_BIT] && !io_mode_q[DIR_POL_BIT] && !core_dir_minus_i
            |=> !minus_dir_out_o;
    endproperty
    a_dir_pol: assert property (p_dir_pol) else $error("plus dir not low");

    property p_updown;
        io_mode_q[ENC_TYPE_BIT] && $rose(enc2_q[0]) && !$rose(enc2_q[1])
            |=> pos_q == $past(pos_q) + POS_W'(1);
    endproperty
    a_updown: assert property (p_updown) else $error("up pulse not counted");

    property p_div_bad;
        !io_mode_q[ENC_TYPE_BIT] && io_mode_q[ENC_DIV_LSB +: 2] == 2'b11
            |=> $stable(pos_q);
    endproperty
    a_div_bad: assert property (p_div_bad) else $error("count on invalid div");

    property p_alarm;
        alarm_act |=> alarm_q && drive_stop_o;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm not latched");

    property p_inpos;
        busy_q && !core_state_i.pulsing && io_mode_q[INP_EN_BIT] && !inp_act
            |=> axis_drive_busy_o;
    endproperty
    a_inpos: assert property (p_inpos) else $error("busy dropped early");

    property p_cont;
        ext_mode == EXT_CONT && !filt_q[8] |=> ext_req_o.cont_plus;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous req missing");

    property p_outsel;
        !drv_filt_q[OUT_SRC_BIT] ##1 $stable(gen_out_q) |-> axis_outputs_o == gen_out_q;
    endproperty
    a_outsel: assert property (p_outsel) else $error("general output wrong");

    property p_filt_pass;
        !fen[7] |=> filt_q[7] == $past(sync2_q[7]);
    endproperty
    a_filt_pass: assert property (p_filt_pass) else $error("pass-through broken");

    c_alarm:  cover property (alarm_act ##1 alarm_q);
    c_pulsar: cover property (ext_mode == EXT_PULSAR ##1 ext_req_o.fixed_minus);
    c_filter: cover property (fen[8] && tick ##1 $changed(filt_q[8]));
endmodule

/* File: src/axis_mode_pkg.sv */
package axis_mode_pkg;
    // register indices on the plain port
    localparam logic [2:0] IO_MODE_ADDR   = 3'h0;
    localparam logic [2:0] DRV_FILT_ADDR  = 3'h1;
    localparam logic [2:0] GEN_OUT_ADDR   = 3'h2;
    localparam logic [2:0] MAIN_STAT_ADDR = 3'h3;
    localparam logic [2:0] ERR_STAT_ADDR  = 3'h4;
    localparam logic [2:0] POS_LO_ADDR    = 3'h5;
    localparam logic [2:0] POS_HI_ADDR    = 3'h6;
    // reset values
    localparam logic [15:0] IO_MODE_RST  = 16'h0000;
    localparam logic [15:0] DRV_FILT_RST = 16'h0000;
    localparam logic [7:0]  GEN_OUT_RST  = 8'h00;
    localparam logic [15:0] FILT_RST     = 16'hffff;
    // io mode fields
    localparam int PULSE_FMT_BIT  = 6;
    localparam int PULSE_POL_BIT  = 7;
    localparam int DIR_POL_BIT    = 8;
    localparam int ENC_TYPE_BIT   = 9;
    localparam int ENC_DIV_LSB    = 10;
    localparam int ALM_LEVEL_BIT  = 12;
    localparam int ALM_EN_BIT     = 13;
    localparam int INP_LEVEL_BIT  = 14;
    localparam int INP_EN_BIT     = 15;
    // drive and filter mode fields
    localparam int MAN_DECEL_BIT  = 0;
    localparam int SEP_DECEL_BIT  = 1;
    localparam int SCURVE_BIT     = 2;
    localparam int EXT_MODE_LSB   = 3;
    localparam int TRI_PREV_BIT   = 5;
    localparam int RING_EN_BIT    = 6;
    localparam int OUT_SRC_BIT    = 7;
    localparam int FILT_EN_LSB    = 8;
    localparam int FILT_CODE_LSB  = 13;
    // status bit positions
    localparam int BUSY_BIT       = 0;
    localparam int ALARM_BIT      = 14;
    // filter timing: base delay, and long delays as base multiples
    localparam int CLK_PERIOD_NS  = 50;
    localparam int FILT_BASE_NS   = 2000;
    localparam int FILT_BASE_CYC  = (FILT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_LONG_US   = 256;
    localparam int FILT_LONG_TICK = FILT_LONG_US * 1000 / FILT_BASE_NS;

    typedef enum logic [1:0] {EXT_OFF, EXT_CONT, EXT_FIXED, EXT_PULSAR} ext_mode_t;

    // profile settings handed to the drive core
    typedef struct packed {
        logic manual_decel_sel;
        logic separate_decel_sel;
        logic scurve_sel;
        logic triangle_prevent;
        logic counter_ring_enable;
    } profile_cfg_t;

    // live drive state reported by the drive core
    typedef struct packed {
        logic decel;
        logic const_speed;
        logic accel;
        logic pulsing;
        logic below_lower;
        logic at_upper;
        logic s_falling;
        logic s_rising;
    } drive_state_t;

    // start requests toward the drive core
    typedef struct packed {
        logic cont_plus;
        logic cont_minus;
        logic fixed_plus;
        logic fixed_minus;
    } ext_req_t;
endpackage

/* File: bench/motor_driver_model.sv */
// servo driver with encoder feedback, stepping on each drive pulse
module motor_driver_model #(
    parameter int SETTLE = 30
) (
    input  wire logic ref_clk_i,
    input  wire logic pulse_i,
    input  wire logic dir_i,
    input  wire logic updown_i,
    output logic      enc_a_o,
    output logic      enc_b_o,
    output logic      inpos_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       pulse_q = 1'b0;
    logic       dir_q   = 1'b0;
    logic [1:0] ph_q    = 2'h0;
    logic [2:0] hold_q  = 3'h0;
    int         quiet_q = 1000;
    // one shaft step per rising pulse; a low direction line means plus
    always @(posedge ref_clk_i) begin
        pulse_q <= pulse_i;
        if (pulse_i && !pulse_q) begin
            ph_q    <= dir_i ? ph_q - 2'h1 : ph_q + 2'h1;
            dir_q   <= dir_i;
            hold_q  <= 3'h4;
            quiet_q <= 0;
        end else begin
            hold_q  <= (hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0;
            quiet_q <= quiet_q + 1;
        end
    end
    // quadrature has a leading a for plus; up/down pulses one line per direction
    assign enc_a_o   = updown_i ? (hold_q != 3'h0 && !dir_q) : (ph_q == 2'h1 || ph_q == 2'h2);
    assign enc_b_o   = updown_i ? (hold_q != 3'h0 && dir_q) : ph_q[1];
    // in-position is active low once the shaft has settled
    assign inpos_n_o = quiet_q < SETTLE;
endmodule

/* File: bench/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import axis_mode_pkg::*;
    logic         ref_clk_i        = 1'b0;
    logic         sys_rst_i        = 1'b1;
    logic [2:0]   reg_addr_i       = 3'h0;
    logic [15:0]  reg_wdata_i      = 16'h0000;
    logic         reg_wr_i         = 1'b0;
    logic         reg_rd_i         = 1'b0;
    logic         core_pulse_i     = 1'b0;
    logic         core_dir_minus_i = 1'b0;
    drive_state_t core_state_i     = '0;
    logic [15:0]  raw_in_i         = 16'hffff;
    logic         updown           = 1'b0;
    logic [15:0]  reg_rdata_o;
    logic [15:0]  filtered_in_o;
    logic [15:0]  pins;
    logic [15:0]  rd;
    profile_cfg_t profile_cfg_o;
    ext_req_t     ext_req_o;
    logic         drive_stop_o;
    logic         axis_drive_busy_o;
    logic         pulse_plus_out_o;
    logic         minus_dir_out_o;
    logic [7:0]   axis_outputs_o;
    logic         enc_a;
    logic         enc_b;
    logic         inpos_n;
    logic         ep;
    logic         em;
    logic [6:0]   wbus;
    int           n_errors         = 0;
    int           cmp_count        = 0;
    logic [15:0]  qm[7] = '{16'h0040, 16'h0440, 16'h0840, 16'h0c40, 16'h0040, 16'h0a40, 16'h0a40};
    int           qn[7] = '{8, 8, 8, 4, -4, 4, -2};
    int           qe[7] = '{8, 12, 14, 14, 10, 14, 12};

    // watched flags: ext requests, filtered ext plus, stop, busy
    assign wbus = {axis_drive_busy_o, drive_stop_o, filtered_in_o[8], ext_req_o};
    assign pins = {raw_in_i[15:7], inpos_n, raw_in_i[5:0]};

    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    axis_drive_mode_config uut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .core_pulse_i(core_pulse_i),
        .core_dir_minus_i(core_dir_minus_i), .core_state_i(core_state_i),
        .profile_cfg_o(profile_cfg_o), .ext_req_o(ext_req_o), .drive_stop_o(drive_stop_o),
        .axis_drive_busy_o(axis_drive_busy_o), .filtered_in_o(filtered_in_o),
        .raw_in_i(pins), .encoder_a_up_in_i(enc_a), .encoder_b_down_in_i(enc_b),
        .pulse_plus_out_o(pulse_plus_out_o), .minus_dir_out_o(minus_dir_out_o),
        .axis_outputs_o(axis_outputs_o)
    );

    motor_driver_model drv (
        .ref_clk_i(ref_clk_i), .pulse_i(pulse_plus_out_o), .dir_i(minus_dir_out_o),
        .updown_i(updown), .enc_a_o(enc_a), .enc_b_o(enc_b), .inpos_n_o(inpos_n)
    );

    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rdr(input logic [2:0] a);
        @(posedge ref_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 rd = reg_rdata_o;
        @(posedge ref_clk_i);
    endtask

    // bounded wait for one watched flag; a timeout ends the run
    task automatic wt(input int i, input logic v, input int lim);
        #1;
        for (int k = 0; k < lim && wbus[i] !== v; k++) begin
            @(posedge ref_clk_i);
            #1;
        end
        chk(wbus[i], v);
        if (wbus[i] !== v) results();
        @(posedge ref_clk_i);
    endtask

    task automatic steps(input int n, input logic dir);
        repeat (n) begin
            @(posedge ref_clk_i);
            core_pulse_i     <= 1'b1;
            core_dir_minus_i <= dir;
            cyc(2);
            core_pulse_i <= 1'b0;
            cyc(6);
        end
    endtask

    initial begin
        cyc(6);
        sys_rst_i <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rdr(3'(a));
            chk(rd, 16'h0000);
        end
        $display("test reset done");
        // profile bits reach the drive core
        wr(DRV_FILT_ADDR, 16'h0045);
        rdr(DRV_FILT_ADDR);
        chk(rd, 16'h0045);
        chk(16'(profile_cfg_o), 16'h0015);
        wr(DRV_FILT_ADDR, 16'h0022);
        #1 chk(16'(profile_cfg_o), 16'h000a);
        $display("test profile done");
        // encoder counting through the driver model
        for (int r = 0; r < 7; r++) begin
            wr(IO_MODE_ADDR, qm[r]);
            updown <= qm[r][9];
            steps(qn[r] < 0 ? -qn[r] : qn[r], qn[r] < 0);
            cyc(10);
            rdr(POS_LO_ADDR);
            chk(rd, 16'(qe[r]));
        end
        $display("test encoder done");
        // in-position holds busy after pulsing ends
        wr(IO_MODE_ADDR, 16'h8040);
        updown <= 1'b0;
        core_state_i.pulsing <= 1'b1;
        steps(2, 1'b0);
        core_state_i.pulsing <= 1'b0;
        cyc(5);
        #1 chk(axis_drive_busy_o, 1'b1);
        wt(6, 1'b0, 80);
        wr(IO_MODE_ADDR, 16'h0040);
        core_state_i.pulsing <= 1'b1;
        steps(1, 1'b0);
        core_state_i.pulsing <= 1'b0;
        cyc(2);
        #1 chk(axis_drive_busy_o, 1'b0);
        $display("test busy done");
        // servo alarm level and enable
        wr(IO_MODE_ADDR, 16'h2000);
        raw_in_i[7] <= 1'b0;
        wt(5, 1'b1, 20);
        rdr(ERR_STAT_ADDR);
        chk(rd, 16'h4000);
        raw_in_i[7] <= 1'b1;
        cyc(4);
        wr(ERR_STAT_ADDR, 16'h4000);
        wt(5, 1'b0, 20);
        wr(IO_MODE_ADDR, 16'h3000);
        wt(5, 1'b1, 20);
        wr(IO_MODE_ADDR, 16'h1000);
        wr(ERR_STAT_ADDR, 16'h4000);
        wt(5, 1'b0, 20);
        cyc(10);
        #1 chk(drive_stop_o, 1'b0);
        wr(IO_MODE_ADDR, 16'h0000);
        $display("test alarm done");
        // external drive modes
        wr(DRV_FILT_ADDR, 16'h0008);
        for (int i = 0; i < 2; i++) begin
            raw_in_i[8+i] <= 1'b0;
            wt(3 - i, 1'b1, 10);
            raw_in_i[8+i] <= 1'b1;
            wt(3 - i, 1'b0, 10);
        end
        wr(DRV_FILT_ADDR, 16'h0010);
        for (int i = 0; i < 2; i++) begin
            raw_in_i[8+i] <= 1'b0;
            wt(1 - i, 1'b1, 10);
            raw_in_i[8+i] <= 1'b1;
            cyc(4);
        end
        wr(DRV_FILT_ADDR, 16'h0018);
        raw_in_i[9] <= 1'b0;
        cyc(6);
        raw_in_i[8] <= 1'b0;
        wt(0, 1'b1, 10);
        raw_in_i[8] <= 1'b1;
        wt(1, 1'b1, 10);
        wr(DRV_FILT_ADDR, 16'h0000);
        raw_in_i[8] <= 1'b0;
        cyc(10);
        #1 chk(16'(ext_req_o), 16'h0000);
        $display("test external done");
        // general output versus drive status
        wr(GEN_OUT_ADDR, 16'h00a5);
        cyc(2);
        #1 chk(16'(axis_outputs_o), 16'h00a5);
        wr(DRV_FILT_ADDR, 16'h0080);
        core_state_i <= drive_state_t'(8'h3c);
        cyc(2);
        #1 chk(16'(axis_outputs_o), 16'h003c);
        $display("test outputs done");
        // pulse routing, formats and polarities
        wr(IO_MODE_ADDR, 16'h0000);
        core_pulse_i <= 1'b1;
        cyc(2);
        #1 chk(16'({pulse_plus_out_o, minus_dir_out_o}), 16'h0002);
        wr(IO_MODE_ADDR, 16'h0140);
        cyc(2);
        #1 chk(16'({pulse_plus_out_o, minus_dir_out_o}), 16'h0003);
        wr(IO_MODE_ADDR, 16'h0080);
        core_dir_minus_i <= 1'b1;
        cyc(2);
        #1 chk(16'({pulse_plus_out_o, minus_dir_out_o}), 16'h0002);
        cyc(1);
        core_pulse_i     <= 1'b0;
        core_dir_minus_i <= 1'b0;
        cyc(2);
        #1 chk(16'({pulse_plus_out_o, minus_dir_out_o}), 16'h0003);
        $display("test pulse done");
        // noise filters: pass-through, short and long delay
        wr(DRV_FILT_ADDR, 16'h0000);
        wt(4, 1'b0, 4);
        raw_in_i[8] <= 1'b1;
        wt(4, 1'b1, 4);
        wr(DRV_FILT_ADDR, 16'h0800);
        raw_in_i[8] <= 1'b0;
        cyc(30);
        #1 chk(filtered_in_o[8], 1'b1);
        wt(4, 1'b0, 100);
        wr(DRV_FILT_ADDR, 16'h2800);
        raw_in_i[8] <= 1'b1;
        cyc(4800);
        #1 chk(filtered_in_o[8], 1'b0);
        wt(4, 1'b1, 3000);
        $display("test filter done");
        results();
    end
endmodule
